// ### hscp_pin_mux.sv
// Strap sampling and pin-function selection for the hub configuration pins.
// Assumes pins arrive synchronous to pclk and pads resolve open-drain wires.
`timescale 1ns/1ps
`include "hscp_params.svh"

module hscp_pin_mux
  import hscp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`HSCP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port4_overcurrent_n,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic iface_mode_strap_in,
  output logic iface_mode_strap_out,
  output logic iface_mode_strap_oe,
  input wire logic power_mgmt_strap_n_in,
  output logic power_mgmt_strap_n_out,
  output logic power_mgmt_strap_n_oe,
  input wire logic ctl_scl_low,
  input wire logic ctl_sda_low,
  input wire logic tgt_sda_low,
  input wire logic ss_suspended,
  input wire logic ss_connected,
  output logic eeprom_mode,
  output logic smb_addr_bit1,
  output logic power_switch_enable,
  output logic port4_overcurrent,
  output logic ctl_scl_seen,
  output logic ctl_sda_seen,
  output logic tgt_scl_seen,
  output logic tgt_sda_seen
);

  hscp_state_e state;
  hscp_state_e next_state;
  hscp_strap_s strap;
  hscp_strap_s strap_pins;
  logic capture;
  logic run;

  logic status_output_enable;
  logic next_status_output_enable;
  logic ovc_event;
  logic next_ovc_event;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  logic next_scl_oe;
  logic next_sda_oe;
  logic next_mode_oe;
  logic next_mode_out;
  logic next_pm_oe;
  logic next_pm_out;
  logic next_ovc;
  logic next_ctl_scl_seen;
  logic next_ctl_sda_seen;
  logic next_tgt_scl_seen;
  logic next_tgt_sda_seen;

  function automatic logic addr_hit(input logic [`HSCP_ADDR_W-1:0] a,
                                    input logic [`HSCP_ADDR_W-1:0] r);
    addr_hit = (a == r);
  endfunction

  // Straps are sampled on the first edge after reset release, before any pin is driven.
  always_comb begin
    next_state = state;
    case (state)
      HSCP_CAPTURE: next_state = HSCP_SETTLE;
      HSCP_SETTLE: next_state = HSCP_RUN;
      HSCP_RUN: next_state = HSCP_RUN;
      default: next_state = HSCP_CAPTURE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= HSCP_CAPTURE;
    end else begin
      state <= next_state;
    end
  end

  assign capture = (state == HSCP_CAPTURE);
  assign run = (state == HSCP_RUN);
  assign strap_pins.iface_mode = iface_mode_strap_in;
  assign strap_pins.power_mgmt_n = power_mgmt_strap_n_in;

  // The mode pad carries a pull-up, so an open mode strap captures as EEPROM mode.
  hscp_strap_capture u_capture (
    .pclk(pclk),
    .presetn(presetn),
    .load(capture),
    .pins(strap_pins),
    .strap(strap)
  );

  // Pin direction and role selection.
  always_comb begin
    next_scl_oe = 1'b0;
    next_sda_oe = 1'b0;
    next_ctl_scl_seen = 1'b1;
    next_ctl_sda_seen = 1'b1;
    next_tgt_scl_seen = 1'b1;
    next_tgt_sda_seen = 1'b1;
    if (run && strap.iface_mode) begin
      next_scl_oe = ctl_scl_low;
      next_sda_oe = ctl_sda_low;
      next_ctl_scl_seen = scl_in;
      next_ctl_sda_seen = sda_in;
    end else if (run) begin
      // The host owns the clock in target mode, so the clock pin is never driven.
      next_sda_oe = tgt_sda_low;
      next_tgt_scl_seen = scl_in;
      next_tgt_sda_seen = sda_in;
    end
    next_mode_oe = run && status_output_enable;
    next_mode_out = ss_suspended;
    next_pm_oe = run && status_output_enable;
    next_pm_out = ss_connected;
    // A power switch strapped off ignores the input, whose pull-up already reads as none.
    next_ovc = !port4_overcurrent_n && !strap.power_mgmt_n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      iface_mode_strap_oe <= 1'b0;
      iface_mode_strap_out <= 1'b0;
      power_mgmt_strap_n_oe <= 1'b0;
      power_mgmt_strap_n_out <= 1'b0;
      port4_overcurrent <= 1'b0;
      ctl_scl_seen <= 1'b1;
      ctl_sda_seen <= 1'b1;
      tgt_scl_seen <= 1'b1;
      tgt_sda_seen <= 1'b1;
    end else begin
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      iface_mode_strap_oe <= next_mode_oe;
      iface_mode_strap_out <= next_mode_out;
      power_mgmt_strap_n_oe <= next_pm_oe;
      power_mgmt_strap_n_out <= next_pm_out;
      port4_overcurrent <= next_ovc;
      ctl_scl_seen <= next_ctl_scl_seen;
      ctl_sda_seen <= next_ctl_sda_seen;
      tgt_scl_seen <= next_tgt_scl_seen;
      tgt_sda_seen <= next_tgt_sda_seen;
    end
  end

  // Open-drain lines only ever pull low.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  // Mode outputs follow the captured straps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_mode <= 1'b1;
      smb_addr_bit1 <= 1'b1;
      power_switch_enable <= 1'b0;
    end else begin
      eeprom_mode <= strap.iface_mode;
      smb_addr_bit1 <= strap.power_mgmt_n;
      power_switch_enable <= !strap.power_mgmt_n && run;
    end
  end

  // APB slave with one wait state so read data can come from a flip-flop.
  always_comb begin
    next_status_output_enable = status_output_enable;
    next_ovc_event = ovc_event;
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (psel && penable && !pready) begin
      if (addr_hit(paddr, `HSCP_CTRL_ADDR)) begin
        next_prdata[`HSCP_CTRL_STSOUT_BIT] = status_output_enable;
      end else if (addr_hit(paddr, `HSCP_STATUS_ADDR)) begin
        next_prdata[`HSCP_ST_MODE_BIT] = strap.iface_mode;
        next_prdata[`HSCP_ST_PMGMT_BIT] = strap.power_mgmt_n;
        next_prdata[`HSCP_ST_PWREN_BIT] = power_switch_enable;
        next_prdata[`HSCP_ST_OVC_BIT] = port4_overcurrent;
        next_prdata[`HSCP_ST_OVC_EVT_BIT] = ovc_event;
        next_prdata[`HSCP_ST_SUSP_BIT] = ss_suspended;
        next_prdata[`HSCP_ST_CONN_BIT] = ss_connected;
        next_prdata[`HSCP_ST_RUN_BIT] = run;
      end else begin
        next_pslverr = 1'b1;
      end
    end
    if (psel && penable && pready && pwrite) begin
      if (addr_hit(paddr, `HSCP_CTRL_ADDR)) begin
        next_status_output_enable = pwdata[`HSCP_CTRL_STSOUT_BIT];
      end else if (addr_hit(paddr, `HSCP_STATUS_ADDR) && pwdata[`HSCP_ST_OVC_EVT_BIT]) begin
        next_ovc_event = 1'b0;
      end
    end
    // Setting after the clear keeps an event that lands on the clearing write.
    if (port4_overcurrent) begin
      next_ovc_event = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_output_enable <= `HSCP_CTRL_RESET;
      ovc_event <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      status_output_enable <= next_status_output_enable;
      ovc_event <= next_ovc_event;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule

// ### hscp_params.svh
// Constants for the hub strap and configuration pin block.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef HSCP_PARAMS_SVH
`define HSCP_PARAMS_SVH

`define HSCP_ADDR_W 12
`define HSCP_CTRL_ADDR 12'h000
`define HSCP_STATUS_ADDR 12'h004

`define HSCP_CTRL_STSOUT_BIT 0
`define HSCP_CTRL_RESET 1'h0

`define HSCP_ST_MODE_BIT 0
`define HSCP_ST_PMGMT_BIT 1
`define HSCP_ST_PWREN_BIT 2
`define HSCP_ST_OVC_BIT 3
`define HSCP_ST_OVC_EVT_BIT 4
`define HSCP_ST_SUSP_BIT 5
`define HSCP_ST_CONN_BIT 6
`define HSCP_ST_RUN_BIT 7

`define HSCP_STRAP_RESET 2'h3

`endif

// ### hscp_pkg.sv
// Types shared by the hub strap and configuration pin block.
// Assumes hscp_params.svh is compiled alongside.
package hscp_pkg;

  typedef struct packed {
    logic iface_mode;
    logic power_mgmt_n;
  } hscp_strap_s;

  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } hscp_pin_s;

  typedef enum logic [2:0] {
    HSCP_CAPTURE = 3'b001,
    HSCP_SETTLE = 3'b010,
    HSCP_RUN = 3'b100
  } hscp_state_e;

endpackage

// ### hscp_strap_capture.sv
// Holds the strap levels taken once after reset release.
// Assumes load is a single-cycle pulse from the sequencer.
`timescale 1ns/1ps
`include "hscp_params.svh"

module hscp_strap_capture
  import hscp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire hscp_strap_s pins,
  output hscp_strap_s strap
);

  hscp_strap_s next_strap;

  // The reset value holds both straps high, power switching off, so early readers see safe modes.
  always_comb begin
    next_strap = strap;
    if (load) begin
      next_strap = pins;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap <= `HSCP_STRAP_RESET;
    end else begin
      strap <= next_strap;
    end
  end

endmodule

// ### hscp_chk.sv
// Port checker for the hub strap and configuration pin block.
// Assumes it is bound to hscp_pin_mux and sees its ports by name.
`timescale 1ns/1ps
module hscp_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic iface_mode_strap_in,
  input wire logic iface_mode_strap_out,
  input wire logic iface_mode_strap_oe,
  input wire logic power_mgmt_strap_n_in,
  input wire logic power_mgmt_strap_n_out,
  input wire logic power_mgmt_strap_n_oe,
  input wire logic port4_overcurrent_n,
  input wire logic ctl_scl_low,
  input wire logic ctl_sda_low,
  input wire logic tgt_sda_low,
  input wire logic ss_suspended,
  input wire logic ss_connected,
  input wire logic eeprom_mode,
  input wire logic smb_addr_bit1,
  input wire logic power_switch_enable,
  input wire logic port4_overcurrent
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Edges since reset release; saturates so a long run never wraps.
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic run;
  always_comb next_cnt = (cnt == 3'h7) ? cnt : cnt + 3'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 3'h0;
    else cnt <= next_cnt;
  end
  assign run = cnt >= 3'h5;
  a_scl_ctl_drive: assert property (run && eeprom_mode && ctl_scl_low |=> scl_oe)
    else $error("clock not driven in controller mode");
  a_scl_tgt_quiet: assert property (!eeprom_mode |-> !scl_oe)
    else $error("clock driven in target mode");
  a_sda_follow_role: assert property (run |=>
    sda_oe == $past(eeprom_mode ? ctl_sda_low : tgt_sda_low))
    else $error("data drive does not follow role");
  a_ovc_level: assert property (run |=> port4_overcurrent ==
    (!$past(port4_overcurrent_n) && $past(power_switch_enable)))
    else $error("overcurrent flag wrong");
  a_pwr_strap_enable: assert property (run |-> power_switch_enable == !smb_addr_bit1)
    else $error("power switching does not match strap");
  a_mode_capture: assert property (cnt == 3'h2 |->
    eeprom_mode == $past(iface_mode_strap_in, 2))
    else $error("mode strap not captured");
  a_pwr_capture: assert property (cnt == 3'h2 |->
    smb_addr_bit1 == $past(power_mgmt_strap_n_in, 2))
    else $error("power strap not captured");
  a_strap_quiet_reset: assert property (cnt < 3'h3 |->
    !iface_mode_strap_oe && !power_mgmt_strap_n_oe)
    else $error("strap pin driven too early");
  a_susp_status: assert property (run && iface_mode_strap_oe |->
    iface_mode_strap_out == $past(ss_suspended))
    else $error("suspend status wrong");
  a_conn_status: assert property (run && power_mgmt_strap_n_oe |->
    power_mgmt_strap_n_out == $past(ss_connected))
    else $error("connection status wrong");
endmodule
bind hscp_pin_mux hscp_chk u_chk (.*);

// ### hscp_far_side.sv
// Far-side model: pulled pads, strap drivers, host clock and power switch fault.
// Assumes the bench drives straps only while it wants them captured.
`timescale 1ns/1ps
module hscp_far_side
  import hscp_pkg::*;
(
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic host_scl_low,
  input wire logic host_sda_low,
  input wire logic strap_drive,
  input wire hscp_strap_s strap,
  input wire logic switch_fault,
  input wire logic iface_mode_strap_oe,
  input wire logic iface_mode_strap_out,
  input wire logic power_mgmt_strap_n_oe,
  input wire logic power_mgmt_strap_n_out,
  output logic scl_in,
  output logic sda_in,
  output logic iface_mode_strap_in,
  output logic power_mgmt_strap_n_in,
  output logic port4_overcurrent_n
);
  // Bus lines are open drain with a pull-up, so any party may hold them low.
  assign scl_in = !(scl_oe || host_scl_low);
  assign sda_in = !(sda_oe || host_sda_low);
  // An undriven strap falls to its pad pull, never to the last value.
  assign iface_mode_strap_in = iface_mode_strap_oe ? iface_mode_strap_out :
    (strap_drive ? strap.iface_mode : 1'b1);
  assign power_mgmt_strap_n_in = power_mgmt_strap_n_oe ? power_mgmt_strap_n_out :
    (strap_drive ? strap.power_mgmt_n : 1'b0);
  assign port4_overcurrent_n = !switch_fault;
endmodule

// ### hub_strap_and_config_pins_tb.sv
// Self-checking bench for the hub strap and configuration pin block.
// Assumes hscp_far_side stands on the pins and the checker is bound.
`timescale 1ns/1ps
module hub_strap_and_config_pins_tb;
  import hscp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
  logic iface_mode_strap_in, iface_mode_strap_out, iface_mode_strap_oe;
  logic power_mgmt_strap_n_in, power_mgmt_strap_n_out, power_mgmt_strap_n_oe;
  logic port4_overcurrent_n, eeprom_mode, smb_addr_bit1, power_switch_enable;
  logic port4_overcurrent, ctl_scl_seen, ctl_sda_seen, tgt_scl_seen, tgt_sda_seen;
  logic ctl_scl_low = 0, ctl_sda_low = 0, tgt_sda_low = 0, ss_suspended = 0;
  logic ss_connected = 0, host_scl_low = 0, host_sda_low = 0, strap_drive = 1;
  logic switch_fault = 0;
  hscp_strap_s strap = 2'h3;
  int failures = 0, check_count = 0;
  // Rows: mode, power strap, ctl clock, ctl data, target data, fault, host clock;
  // then clock oe, data oe, overcurrent, power enable, ctl clock seen, target clock seen,
  // ctl data seen, target data seen.
  logic [14:0] rows [5] = '{15'h56B7, 15'h6A4D, 15'h191B, 15'h264E, 15'h023F};
  hscp_pin_mux DUT (.*);
  hscp_far_side u_far (.*);
  always #10 pclk = ~pclk;
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets its answer.
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge pclk);
    failures++;
    report_and_stop();
  end
  initial begin
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      {strap, ctl_scl_low, ctl_sda_low, tgt_sda_low, switch_fault, host_scl_low} <= rows[i][14:8];
      do_reset();
      repeat (3) @(posedge pclk);
      #1;
      chk("mode", eeprom_mode, rows[i][14]);
      chk("addr1", smb_addr_bit1, rows[i][13]);
      chk("pins", {scl_oe, sda_oe, port4_overcurrent, power_switch_enable, ctl_scl_seen,
        tgt_scl_seen, ctl_sda_seen, tgt_sda_seen}, rows[i][7:0]);
    end
    // Released straps must fall back to their pulls.
    @(posedge pclk);
    {strap_drive, switch_fault, host_scl_low} <= 3'h0;
    do_reset();
    #1;
    chk("float", {eeprom_mode, port4_overcurrent}, 2'h2);
    chk("od out", {scl_out, sda_out}, 2'h0);
    chk("pins off", {iface_mode_strap_oe, power_mgmt_strap_n_oe}, 2'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", {err, rd}, 33'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", {err, rd}, 33'h100000000);
    switch_fault <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk("status", rd, 32'h9D);
    switch_fault <= 1'b0;
    apb(1'b1, 12'h004, 32'h10);
    apb(1'b0, 12'h004, 32'h0);
    chk("cleared", rd, 32'h85);
    apb(1'b1, 12'h000, 32'h1);
    ss_suspended <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("status pins", {iface_mode_strap_oe, iface_mode_strap_out, power_mgmt_strap_n_oe,
      power_mgmt_strap_n_out}, 4'hE);
    @(posedge pclk);
    ss_suspended <= 1'b0;
    ss_connected <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk("status swap", {iface_mode_strap_oe, iface_mode_strap_out, power_mgmt_strap_n_oe,
      power_mgmt_strap_n_out}, 4'hB);
    report_and_stop();
  end
endmodule
